/* File: bct_cfg.svh */
/*
 Constants of the self test and cache test access block: register
 selectors, operation codes, reset values and timing counts.
 Assumes it is included once per compile unit by its bare name.
*/
`ifndef BCT_CFG_SVH
`define BCT_CFG_SVH

// Test register selectors on the move port
`define BCT_SEL_DATA 2'h0
`define BCT_SEL_STAT 2'h1
`define BCT_SEL_CTL 2'h2

// Control field codes
`define BCT_OP_BUF 2'h0
`define BCT_OP_WR 2'h1
`define BCT_OP_RD 2'h2
`define BCT_OP_FLUSH 2'h3

// Reset values
`define BCT_REG_RST 32'h0000_0000

// Self test length in clocks, about 42 ms at 25 MHz
`define BCT_BIST_CYCLES 1048576
// Last step of one entry test sequence
`define BCT_LAST_STEP 5'h12
// Test patterns for the two passes
`define BCT_PAT0 32'h5555_5555
`define BCT_PAT1 32'hAAAA_AAAA

`endif

/* File: bct_pkg.sv */
/*
 Types of the self test and cache test access block.
 Assumes bct_cfg.svh is available for the constants.
*/
package bct_pkg;

    // Control test register layout
    typedef struct packed {
        logic [20:0] rsvd;
        logic [6:0] set;
        logic [1:0] entry;
        logic [1:0] code;
    } bct_ctl_t;

    // Status test register layout
    typedef struct packed {
        logic [20:0] tag;
        logic valid;
        logic [2:0] lru;
        logic [3:0] setv;
        logic [2:0] rsvd;
    } bct_stat_t;

    // One register move
    typedef struct packed {
        logic wr;
        logic rd;
        logic [1:0] sel;
        logic [31:0] data;
    } bct_acc_t;

    // Self test sequencer states
    typedef enum logic [4:0] {
        ST_ARM = 5'b00001,
        ST_CACHE = 5'b00010,
        ST_PAD = 5'b00100,
        ST_FIN = 5'b01000,
        ST_NORM = 5'b10000
    } bct_state_t;

endpackage

/* File: bct_top.sv */
/*
 Self test sequencer and cache test register path with the cache
 arrays. Assumes strap pins are stable around the release of reset
 and that the neighbouring ROM, TLB and logic checks report on ports.
*/
// Contract
// - test mode floats all outputs
// - self test runs two-to-twenty clocks
// - no bus cycles during self test
// - result left in accumulator, zero passes
// - reset then normal operation after test
// - test covers logic, ROM, cache, TLB
// - cache test writes, reads, compares entries
// - cache test uses the test registers
// - 128-bit fill and read buffers
// - buffers reached via data register only
// - entry select picks buffer word
// - cache read loads tag, valid, lru
// - set select picks one of 128
// - code 00 is buffer access
// - code 01 writes fill buffer to entry
// - code 10 reads entry to buffer
// - code 11 flushes, selects ignored
// - data write fills selected word now
// - flush clears lru, valid; no bus
`include "bct_cfg.svh"
`timescale 1ns/100ps
`default_nettype none

module bct_top
    import bct_pkg::*;
#(
    parameter int BIST_CYCLES = `BCT_BIST_CYCLES,
    parameter logic [31:0] ROM_SIG = 32'h0000_0000 // Arbitrary value
) (
    // Clock and reset pin
    input wire logic clk_i,
    input wire logic rst_i,
    // Strap and test pins
    input wire logic address_hold_input,
    input wire logic flush_n_i,
    input wire logic a20_mask_pin_n_i,
    input wire logic float_test_i,
    // Reports from neighbouring checks
    input wire logic [31:0] rom_sig_i,
    input wire logic tlb_pass_i,
    input wire logic logic_pass_i,
    // Test register move port
    input wire logic [1:0] treg_sel_i,
    input wire logic treg_wr_i,
    input wire logic treg_rd_i,
    input wire logic [31:0] treg_wdata_i,
    output logic [31:0] treg_rdata_o,
    // Core status
    output logic bist_active_o,
    output logic core_reset_o,
    output logic bus_enable_o,
    output logic pins_oe_o,
    output logic [31:0] bist_result_o
);

    bct_state_t st_q;
    logic [2:0] s1_q, s2_q, s3_q, filt_q, raw;
    logic address_hold_input_q;
    logic [19:0] cyc_q;
    logic [4:0] step_q;
    logic [8:0] ent_q;
    logic pass_q, cache_done_q, cache_err_q;
    logic core_rst_q, bus_en_q, oe_q;
    logic [31:0] res_q, rdata_q, data_q;
    bct_ctl_t ctl_q, ctl_w;
    bct_stat_t stat_q;
    bct_acc_t sw_acc, bi_acc, acc;
    logic [3:0][31:0] fill_q, rbuf_q;
    logic [127:0] data_mem [0:511];
    logic [20:0] tag_mem [0:511];
    logic [511:0] valid_q;
    logic [127:0][2:0] lru_q;
    logic op_wr, op_rd, op_fl;
    logic [8:0] idx;
    logic [31:0] exp_w;
    logic [31:0] tag_pat;

    // Pseudo LRU tree: bit0 pairs, bit1 ways 0/1, bit2 ways 2/3
    function automatic logic [2:0] plru(input logic [2:0] l, input logic [1:0] w);
        logic [2:0] n;
        n = l;
        n[0] = ~w[1];
        if (w[1]) begin
            n[2] = ~w[0];
        end else begin
            n[1] = ~w[0];
        end
        return n;
    endfunction

    // Pattern of one word for a pass, entry and word slot
    function automatic logic [31:0] pat(input logic p, input logic [8:0] e, input logic [1:0] w);
        return (p ? `BCT_PAT1 : `BCT_PAT0) ^ {21'h0, w, e};
    endfunction

    // Three stage pin synchronisers, no reset so straps survive reset
    assign raw = {float_test_i, flush_n_i, a20_mask_pin_n_i};
    for (genvar g = 0; g < 3; g++) begin : g_sync
        always_ff @(posedge clk_i) begin
            s1_q[g] <= raw[g];
            s2_q[g] <= s1_q[g];
            s3_q[g] <= s2_q[g];
            if (s2_q[g] == s3_q[g]) begin
                filt_q[g] <= s3_q[g];
            end
        end
    end

    // Synchronous strap, sampled every clock; ST_ARM sees the level of the last reset cycle
    always_ff @(posedge clk_i) begin
        address_hold_input_q <= address_hold_input;
    end

    // Self test sequencer state
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            st_q <= ST_ARM;
        end else begin
            unique case (st_q)
                ST_ARM: begin
                    // Start needs hold high, invalidate low, a20 mask high
                    if (address_hold_input_q && !filt_q[1] && filt_q[0]) begin
                        st_q <= ST_CACHE;
                    end else begin
                        st_q <= ST_NORM;
                    end
                end
                ST_CACHE: begin
                    if (cache_done_q) begin
                        st_q <= ST_PAD;
                    end
                end
                ST_PAD: begin
                    if (cyc_q >= 20'(BIST_CYCLES - 1)) begin
                        st_q <= ST_FIN;
                    end
                end
                ST_FIN: st_q <= ST_NORM;
                ST_NORM: st_q <= ST_NORM;
            endcase
        end
    end

    // Run length counter, stops at the full count
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            cyc_q <= 20'h0_0000;
        end else if (bist_active_o && cyc_q < 20'(BIST_CYCLES - 1)) begin
            cyc_q <= cyc_q + 20'h0_0001;
        end
    end

    // Cache test step walker: entry, step and pass
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            step_q <= 5'h00;
            ent_q <= 9'h000;
            pass_q <= 1'b0;
            cache_done_q <= 1'b0;
        end else if (st_q == ST_CACHE && !cache_done_q) begin
            if (step_q == `BCT_LAST_STEP) begin
                step_q <= 5'h00;
                ent_q <= ent_q + 9'h001;
                if (ent_q == 9'h1FF) begin
                    pass_q <= 1'b1;
                    cache_done_q <= pass_q;
                end
            end else begin
                step_q <= step_q + 5'h01;
            end
        end
    end

    // Tag pattern of the entry under test, word slot zero
    assign tag_pat = pat(pass_q, ent_q, 2'h0);

    // Self test moves driven through the same test registers
    always_comb begin
        bi_acc = '0;
        exp_w = pat(pass_q, ent_q, 2'((step_q - 5'h0B) >> 1));
        if (st_q == ST_CACHE && !cache_done_q) begin
            if (step_q < 5'h08) begin
                bi_acc.wr = 1'b1;
                bi_acc.sel = step_q[0] ? `BCT_SEL_DATA : `BCT_SEL_CTL;
                bi_acc.data = step_q[0] ? pat(pass_q, ent_q, step_q[2:1]) : {28'h0, step_q[2:1], `BCT_OP_BUF};
            end else if (step_q == 5'h08) begin
                bi_acc.wr = 1'b1;
                bi_acc.sel = `BCT_SEL_STAT;
                bi_acc.data = {tag_pat[20:0], 1'b1, 10'h000};
            end else if (step_q < 5'h0B) begin
                bi_acc.wr = 1'b1;
                bi_acc.sel = `BCT_SEL_CTL;
                bi_acc.data = {21'h0, ent_q, step_q[0] ? `BCT_OP_WR : `BCT_OP_RD};
            end else if (step_q[0]) begin
                bi_acc.wr = 1'b1;
                bi_acc.sel = `BCT_SEL_CTL;
                bi_acc.data = {28'h0, 2'((step_q - 5'h0B) >> 1), `BCT_OP_BUF};
            end else begin
                bi_acc.rd = 1'b1;
                bi_acc.sel = `BCT_SEL_DATA;
            end
        end
    end

    // Software moves are locked out while self test owns the path
    always_comb begin
        sw_acc.wr = treg_wr_i && !bist_active_o;
        sw_acc.rd = treg_rd_i && !bist_active_o;
        sw_acc.sel = treg_sel_i;
        sw_acc.data = treg_wdata_i;
        acc = bist_active_o ? bi_acc : sw_acc;
    end

    // Cache operation decode on a control register write
    assign ctl_w = bct_ctl_t'(acc.data);
    assign idx = {ctl_w.set, ctl_w.entry};
    assign op_wr = acc.wr && acc.sel == `BCT_SEL_CTL && ctl_w.code == `BCT_OP_WR;
    assign op_rd = acc.wr && acc.sel == `BCT_SEL_CTL && ctl_w.code == `BCT_OP_RD;
    assign op_fl = acc.wr && acc.sel == `BCT_SEL_CTL && ctl_w.code == `BCT_OP_FLUSH;

    // Compare read buffer against the written pattern
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            cache_err_q <= 1'b0;
        end else if (bi_acc.rd && rbuf_q[ctl_q.entry] != exp_w) begin
            cache_err_q <= 1'b1;
        end else if (st_q == ST_CACHE && step_q == 5'h0B && !stat_q.valid) begin
            cache_err_q <= 1'b1;
        end
    end

    // Control and data test registers
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            ctl_q <= bct_ctl_t'(`BCT_REG_RST);
            data_q <= `BCT_REG_RST;
        end else if (acc.wr) begin
            if (acc.sel == `BCT_SEL_CTL) begin
                ctl_q <= ctl_w;
            end
            if (acc.sel == `BCT_SEL_DATA) begin
                data_q <= acc.data;
            end
        end
    end

    // Fill buffer word load in buffer mode only
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            fill_q <= '0;
        end else if (acc.wr && acc.sel == `BCT_SEL_DATA && ctl_q.code == `BCT_OP_BUF) begin
            fill_q[ctl_q.entry] <= acc.data;
        end
    end

    // Status register: a cache read overrides a same-cycle load
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            stat_q <= bct_stat_t'(`BCT_REG_RST);
        end else if (op_rd) begin
            stat_q <= {tag_mem[idx], valid_q[idx], lru_q[ctl_w.set],
                       valid_q[{ctl_w.set, 2'h0} +: 4], 3'h0};
        end else if (acc.wr && acc.sel == `BCT_SEL_STAT) begin
            stat_q <= bct_stat_t'(acc.data);
        end
    end

    // Tag and data arrays, no reset; flush leaves them alone
    always_ff @(posedge clk_i) begin
        if (op_wr) begin
            data_mem[idx] <= fill_q;
            tag_mem[idx] <= stat_q.tag;
        end
    end

    // Read buffer, caller must drain it before other memory use
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            rbuf_q <= '0;
        end else if (op_rd) begin
            rbuf_q <= data_mem[idx];
        end
    end

    // Valid and LRU bits; flush clears all and issues no bus cycle
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            valid_q <= '0;
            lru_q <= '0;
        end else if (op_fl) begin
            valid_q <= '0;
            lru_q <= '0;
        end else if (op_wr) begin
            valid_q[idx] <= stat_q.valid;
            lru_q[ctl_w.set] <= plru(lru_q[ctl_w.set], ctl_w.entry);
        end
    end

    // Register read data, unmapped selector reads zero
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            rdata_q <= `BCT_REG_RST;
        end else if (sw_acc.rd) begin
            unique case (sw_acc.sel)
                `BCT_SEL_DATA: rdata_q <= (ctl_q.code == `BCT_OP_BUF) ? rbuf_q[ctl_q.entry] : data_q;
                `BCT_SEL_STAT: rdata_q <= stat_q;
                `BCT_SEL_CTL: rdata_q <= ctl_q;
                default: rdata_q <= 32'h0000_0000;
            endcase
        end
    end

    // Result, core reset pulse, bus gate and pin float
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            res_q <= `BCT_REG_RST;
            core_rst_q <= 1'b0;
            bus_en_q <= 1'b0;
            oe_q <= 1'b0;
        end else begin
            core_rst_q <= (st_q == ST_FIN);
            bus_en_q <= (st_q == ST_NORM) && !core_rst_q;
            oe_q <= !filt_q[2];
            if (st_q == ST_FIN) begin
                res_q <= {28'h0, !logic_pass_i, !tlb_pass_i, rom_sig_i != ROM_SIG, cache_err_q};
            end
        end
    end

    assign bist_active_o = (st_q == ST_CACHE) || (st_q == ST_PAD);
    assign core_reset_o = core_rst_q;
    assign bus_enable_o = bus_en_q;
    assign pins_oe_o = oe_q;
    assign bist_result_o = res_q;
    assign treg_rdata_o = rdata_q;

    // Checks
    chk_float_pins: assert property (@(posedge clk_i) disable iff (rst_i)
        filt_q[2] |=> !pins_oe_o) else $error("pins driven in float mode");
    chk_no_bus_test: assert property (@(posedge clk_i) disable iff (rst_i)
        bist_active_o |-> !bus_enable_o) else $error("bus enabled in self test");
    chk_run_length: assert property (@(posedge clk_i) disable iff (rst_i)
        $fell(bist_active_o) |-> $past(cyc_q) == 20'(BIST_CYCLES - 1)) else $error("self test length wrong");
    // Bus gate is registered behind the pulse, so it opens one clock after it drops; checked two clocks after
    chk_reset_pulse: assert property (@(posedge clk_i) disable iff (rst_i)
        $fell(bist_active_o) |-> ##1 core_reset_o ##1 !core_reset_o ##2 bus_enable_o) else $error("no reset after test");
    chk_result_load: assert property (@(posedge clk_i) disable iff (rst_i)
        $rose(core_reset_o) |-> bist_result_o[0] == cache_err_q) else $error("result not in accumulator");
    chk_fill_word: assert property (@(posedge clk_i) disable iff (rst_i)
        acc.wr && acc.sel == `BCT_SEL_DATA && ctl_q.code == `BCT_OP_BUF
        |=> fill_q[$past(ctl_q.entry)] == $past(acc.data)) else $error("fill word not loaded");
    chk_flush_clear: assert property (@(posedge clk_i) disable iff (rst_i)
        op_fl |=> valid_q == '0 && lru_q == '0) else $error("flush left bits set");
    chk_write_valid: assert property (@(posedge clk_i) disable iff (rst_i)
        op_wr |=> valid_q[$past(idx)] == $past(stat_q.valid)) else $error("entry valid not written");
    chk_read_status: assert property (@(posedge clk_i) disable iff (rst_i)
        op_rd |=> stat_q.valid == $past(valid_q[idx]) && rbuf_q == $past(data_mem[idx])) else $error("read status wrong");
    cov_bist_run: cover property (@(posedge clk_i) disable iff (rst_i) $rose(core_reset_o));
    cov_cache_wr: cover property (@(posedge clk_i) disable iff (rst_i) op_wr && !bist_active_o);
    cov_flush: cover property (@(posedge clk_i) disable iff (rst_i) op_fl);

endmodule

`default_nettype wire

/* File: bct_sys_model.sv */
/*
 Partner model: system reset logic that drives the reset and strap pins.
 Assumes one clock shared with the block; the bench calls warm_reset.
*/
`timescale 1ns/100ps
`default_nettype none

module bct_sys_model (
    // Clock
    input wire logic clk_i,
    // Reset and strap pins
    output logic rst_i,
    output logic address_hold_input,
    output logic flush_n_i,
    output logic a20_mask_pin_n_i
);
    // Short cold reset with idle straps, so no self test
    initial begin
        rst_i = 1'b1;
        address_hold_input = 1'b0;
        flush_n_i = 1'b1;
        a20_mask_pin_n_i = 1'b1;
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
    end

    // Warm reset; a long hold lets the pin synchronisers settle
    task automatic warm_reset(input logic bist, input int clocks);
        @(posedge clk_i);
        rst_i <= 1'b1;
        flush_n_i <= ~bist;
        a20_mask_pin_n_i <= 1'b1;
        repeat (clocks - 2) @(posedge clk_i);
        address_hold_input <= bist;
        @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        address_hold_input <= 1'b0;
        flush_n_i <= 1'b1;
    endtask
endmodule

`default_nettype wire

/* File: bist_and_cache_test_access_test.sv */
/*
 Self-checking bench: register moves against a cache model, flush,
 float mode and two self test runs. Assumes bct_top and bct_sys_model.
*/
`timescale 1ns/100ps
`default_nettype none

module bist_and_cache_test_access_test;
    import bct_pkg::*;
    localparam int BC = 20000;
    logic clk_i = 1'b0;
    logic rst_i, address_hold_input, flush_n_i, a20_mask_pin_n_i;
    logic float_test_i = 1'b0, tlb_pass_i = 1'b1, logic_pass_i = 1'b1;
    logic treg_wr_i = 1'b0, treg_rd_i = 1'b0;
    logic [1:0] treg_sel_i = 2'h0;
    logic [31:0] rom_sig_i = 32'h0, treg_wdata_i = 32'h0, treg_rdata_o, bist_result_o;
    logic bist_active_o, core_reset_o, bus_enable_o, pins_oe_o;
    logic [31:0] seed = 32'h5, got, r;
    logic [31:0] m_data [0:511][0:3];
    logic [20:0] m_tag [0:511];
    logic m_val [0:511];
    logic [6:0] sets [0:3];
    logic busok;
    int fail_count = 0, n_tests = 0, n;

    // 25 MHz clock
    always #20 clk_i = ~clk_i;

    bct_sys_model sys_u (.clk_i(clk_i), .rst_i(rst_i), .address_hold_input(address_hold_input),
        .flush_n_i(flush_n_i), .a20_mask_pin_n_i(a20_mask_pin_n_i));

    // Shortened self test so a run stays short
    bct_top #(.BIST_CYCLES(BC), .ROM_SIG(32'h0000_0000)) dut_u (.clk_i(clk_i), .rst_i(rst_i),
        .address_hold_input(address_hold_input), .flush_n_i(flush_n_i),
        .a20_mask_pin_n_i(a20_mask_pin_n_i), .float_test_i(float_test_i), .rom_sig_i(rom_sig_i),
        .tlb_pass_i(tlb_pass_i), .logic_pass_i(logic_pass_i), .treg_sel_i(treg_sel_i),
        .treg_wr_i(treg_wr_i), .treg_rd_i(treg_rd_i), .treg_wdata_i(treg_wdata_i),
        .treg_rdata_o(treg_rdata_o), .bist_active_o(bist_active_o), .core_reset_o(core_reset_o),
        .bus_enable_o(bus_enable_o), .pins_oe_o(pins_oe_o), .bist_result_o(bist_result_o));

    // Xorshift source, fixed start
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    function automatic logic [31:0] ctl(input logic [6:0] s, input logic [1:0] e, input logic [1:0] c);
        return {21'h0, s, e, c};
    endfunction

    task automatic chk_word(input logic [31:0] g, input logic [31:0] e, input string what);
        n_tests++;
        if (g !== e) begin
            fail_count++;
            $display("[ERR] %0t %s: got %h expected %h", $time, what, g, e);
        end
    endtask

    task automatic chk_flag(input logic g, input logic e, input string what);
        n_tests++;
        if (g !== e) begin
            fail_count++;
            $display("[ERR] %0t %s: got %b expected %b", $time, what, g, e);
        end
    endtask

    // One register move; strobe dropped an edge later
    task automatic mv_wr(input logic [1:0] sel, input logic [31:0] d);
        @(posedge clk_i);
        treg_sel_i <= sel;
        treg_wdata_i <= d;
        treg_wr_i <= 1'b1;
        @(posedge clk_i);
        treg_wr_i <= 1'b0;
    endtask

    task automatic mv_rd(input logic [1:0] sel, output logic [31:0] d);
        @(posedge clk_i);
        treg_sel_i <= sel;
        treg_rd_i <= 1'b1;
        @(posedge clk_i);
        treg_rd_i <= 1'b0;
        #1 d = treg_rdata_o;
    endtask

    // Flush with junk select bits; model drops every valid bit
    task automatic do_flush();
        r = rnd();
        mv_wr(2'h2, {r[31:2], 2'b11});
        for (int i = 0; i < 512; i++) m_val[i] = 1'b0;
    endtask

    // Cache read into status and read buffer, then drain four words
    task automatic rd_entry(input logic [6:0] s, input logic [1:0] e, input logic lru_known);
        logic [31:0] exp, mask, d;
        int b;
        b = s * 4;
        mv_wr(2'h2, ctl(s, e, 2'h2));
        mv_rd(2'h1, d);
        exp = {m_tag[b + e], m_val[b + e], 3'b000, m_val[b + 3], m_val[b + 2], m_val[b + 1], m_val[b], 3'b000};
        mask = lru_known ? 32'hFFFF_FFFF : 32'hFFFF_FC7F;
        chk_word(d & mask, exp, "status after cache read");
        for (int w = 0; w < 4; w++) begin
            r = rnd();
            mv_wr(2'h2, ctl(r[6:0], w[1:0], 2'h0));
            mv_rd(2'h0, d);
            chk_word(d, m_data[b + e][w], "read buffer word");
        end
    endtask

    // Main sequence
    initial begin
        @(posedge clk_i);
        #1 chk_flag(bus_enable_o, 1'b0, "bus enable in reset");
        chk_word(treg_rdata_o, 32'h0, "read data in reset");
        wait (rst_i === 1'b0);
        repeat (4) @(posedge clk_i);
        #1 chk_flag(bist_active_o, 1'b0, "no self test without straps");
        chk_flag(bus_enable_o, 1'b1, "bus enabled without self test");
        chk_flag(pins_oe_o, 1'b1, "pins driven");
        // Float mode passes a synchroniser, so allow a few clocks
        @(posedge clk_i) float_test_i <= 1'b1;
        repeat (6) @(posedge clk_i);
        #1 chk_flag(pins_oe_o, 1'b0, "pins floated");
        @(posedge clk_i) float_test_i <= 1'b0;
        repeat (6) @(posedge clk_i);
        #1 chk_flag(pins_oe_o, 1'b1, "pins driven again");
        r = rnd();
        mv_wr(2'h2, {r[31:2], 2'b00});
        mv_rd(2'h2, got);
        chk_word(got, {r[31:2], 2'b00}, "control readback");
        mv_wr(2'h3, rnd());
        mv_rd(2'h3, got);
        chk_word(got, 32'h0, "unmapped select");
        // Cache counted as disabled by software from here on
        // Write four entries, boundary sets included, one left invalid
        do_flush();
        sets[0] = 7'h00;
        sets[1] = 7'h7F;
        r = rnd();
        sets[2] = r[6:0];
        sets[3] = r[14:8];
        for (int k = 0; k < 4; k++) begin
            n = sets[k] * 4 + k;
            for (int w = 0; w < 4; w++) begin
                r = rnd();
                mv_wr(2'h2, ctl(r[6:0], w[1:0], 2'h0));
                m_data[n][w] = rnd();
                mv_wr(2'h0, m_data[n][w]);
            end
            r = rnd();
            m_tag[n] = r[20:0];
            m_val[n] = (k != 3);
            mv_wr(2'h1, {m_tag[n], m_val[n], 10'h000});
            mv_wr(2'h2, ctl(sets[k], k[1:0], 2'h1));
        end
        for (int k = 0; k < 4; k++) rd_entry(sets[k], k[1:0], 1'b0);
        do_flush();
        for (int k = 0; k < 4; k++) rd_entry(sets[k], k[1:0], 1'b1);
        // Two self test runs: all pass, then ROM and TLB failures
        for (int b = 0; b < 2; b++) begin
            r = rnd();
            @(posedge clk_i);
            rom_sig_i <= (b == 0) ? 32'h0 : (r | 32'h1);
            tlb_pass_i <= (b == 0);
            sys_u.warm_reset(1'b1, 17);
            repeat (2) @(posedge clk_i);
            #1 chk_flag(bist_active_o, 1'b1, "self test started");
            n = 0;
            busok = 1'b1;
            while (bist_active_o === 1'b1 && n < BC + 100) begin
                @(posedge clk_i);
                #1 n++;
                if (bus_enable_o !== 1'b0) busok = 1'b0;
            end
            chk_flag(busok, 1'b1, "no bus during self test");
            chk_flag(n >= BC - 3 && n <= BC + 3, 1'b1, "self test length");
            n = 0;
            while (core_reset_o !== 1'b1 && n < 5) begin
                @(posedge clk_i);
                #1 n++;
            end
            chk_flag(core_reset_o, 1'b1, "reset after self test");
            chk_word(bist_result_o, (b == 0) ? 32'h0 : 32'h6, "self test result");
            // Bus gate samples the pulse, so it opens one clock after the pulse ends
            repeat (2) @(posedge clk_i);
            #1 chk_flag(bus_enable_o, 1'b1, "normal operation");
        end
        end_sim();
    end

    // Watchdog well beyond two self test runs
    initial begin
        repeat (80000) @(posedge clk_i);
        fail_count++;
        $display("[ERR] %0t watchdog expired", $time);
        end_sim();
    end

    task automatic end_sim();
        $display("Checks %0d, mismatches %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
endmodule

`default_nettype wire
